// File: rtl/tpeu_map.svh
// offsets, field positions, reset values and timing counts of the exception unit
`ifndef TPEU_MAP_SVH
`define TPEU_MAP_SVH
// trace enable field encodings
`define TPEU_TE_EVERY 2'h2
`define TPEU_TE_BRANCH 2'h1
// saved-state field positions, bit 0 is the msb
`define TPEU_S1_LOAD 35
`define TPEU_S1_STORE 36
`define TPEU_S1_MSR_LO 37
`define TPEU_S1_MSR_HI 41
`define TPEU_S1_UNIMP 42
`define TPEU_S1_BKPT 43
`define TPEU_S1_ZERO_LO 44
`define TPEU_S1_ZERO_HI 47
// compatibility register
`define TPEU_PCR_V30 60
`define TPEU_PCR_V207 61
`define TPEU_PCR_V206 62
`define TPEU_PCR_RST 64'h0000_0000_0000_0000
// emulation image recode fields
`define TPEU_IMG_F_LO 11
`define TPEU_IMG_F_HI 20
`define TPEU_IMG_SF_LO 11
`define TPEU_IMG_SF_HI 14
`define TPEU_BHRB_OOR 10'h050
`define TPEU_BHRB_BASE 10'h100
`define TPEU_BHRB_CNT 10'h020
// store gathering
`define TPEU_GATH_MAX 8'h40
`define TPEU_CLK_NS 8
`define TPEU_GATH_WAIT_NS 64
`define TPEU_GATH_WAIT_CYC ((`TPEU_GATH_WAIT_NS) / (`TPEU_CLK_NS))
`endif

// File: rtl/tpeu_pkg.sv
// types shared by the exception unit files
package tpeu_pkg;
    // kind of trapped instruction handed to the image recoder
    typedef enum logic [2:0] {HK_NONE, HK_BHRB_RD, HK_BHRB_CLR, HK_BCTAR, HK_STOPF} tpeu_emulation_instr_image_reg_kind_t;
    // architecture level that introduced a problem-state instruction
    typedef enum logic [1:0] {VER_BASE, VER_206, VER_207, VER_30} tpeu_isa_ver_t;
    // monitor interrupt sequencing
    typedef enum logic [1:0] {PM_IDLE, PM_DRAIN} tpeu_pmu_state_t;
endpackage

// File: rtl/tpeu_emulation_instr_image_reg_recode.sv
// combinational recoder of trapped instructions into the emulation image
`timescale 1ns/10ps
`include "tpeu_map.svh"
module tpeu_emulation_instr_image_reg_recode
    import tpeu_pkg::*;
(
    input wire logic [0:31] instr,         // raw trapped instruction, bit 0 msb
    input wire tpeu_pkg::tpeu_emulation_instr_image_reg_kind_t kind,
    input wire logic [9:0] bhrbIdx,        // selected history entry
    output logic [0:31] image              // recoded image
);
    // in-range history entries map onto consecutive internal numbers
    logic [9:0] bhrbSpr;
    assign bhrbSpr = (bhrbIdx < `TPEU_BHRB_CNT) ?
        10'(`TPEU_BHRB_BASE + bhrbIdx) : `TPEU_BHRB_OOR;

    // one recode per kind; unrecoded positions keep the trapped instruction bits, except in the branch kind, which starts from zero
    always_comb begin
        image = instr;
        case (kind)
            HK_BHRB_RD: begin
                image[`TPEU_IMG_F_LO:`TPEU_IMG_F_HI] = bhrbSpr;
            end
            HK_BHRB_CLR: begin
                image[`TPEU_IMG_F_LO:`TPEU_IMG_F_HI] = `TPEU_BHRB_OOR;
            end
            HK_BCTAR: begin
                // fixed pattern bits; bo(4) is dropped, so it cannot be rebuilt
                image = 32'h0000_0000;
                image[2] = 1'b1;
                image[11:12] = 2'h3;
                image[20] = 1'b1;
                image[23:30] = 8'hB0;
                image[1] = instr[31];
                image[5:8] = instr[6:9];
                image[10] = instr[11];
                image[15:18] = instr[12:15];
                image[21:22] = instr[19:20];
            end
            HK_STOPF: begin
                image[`TPEU_IMG_SF_LO:`TPEU_IMG_SF_HI] = 4'hF;
            end
            default: begin
                image = instr;
            end
        endcase
    end
endmodule

// File: rtl/tpeu_exception_unit.sv
// trace, alignment, monitor, emulation image, compatibility and gather logic
`timescale 1ns/10ps
`include "tpeu_map.svh"
module tpeu_exception_unit
(
    input wire logic clk,                   // core clock
    input wire logic sys_rst,               // synchronous reset, high
    input wire logic cmplValid,             // one instruction completes
    input wire logic [0:63] cmplEa,         // its effective address
    input wire logic [0:63] cmplNextEa,     // address to resume at
    input wire logic [0:63] cmplDataEa,     // its storage address
    input wire logic cmplIsBranch,
    input wire logic cmplIsLoad,
    input wire logic cmplIsStore,
    input wire logic cmplZeroLenStr,        // string access of length zero
    input wire logic [1:0] traceEnableField, // value before the instruction
    input wire logic [0:63] msrBits,        // machine state before the interrupt
    input wire logic externalEnableBit,
    input wire logic monitorAlertEnable,
    input wire logic [7:0] pmcOverflow,     // core counter overflow events
    input wire logic nestOverflow,          // memory-mapped counter overflow
    input wire logic inflightEmpty,         // all prior dispatched done
    input wire logic bkptEnable,
    input wire logic [0:63] instrAddrBreakpointReg,
    input wire logic alignInt,              // alignment interrupt taken
    input wire logic [0:63] alignEa,
    input wire logic causeWrEn,             // software write of cause register
    input wire logic [0:31] causeWrData,
    input wire logic trapValid,             // illegal instruction trapped
    input wire logic [0:31] trapInstr,
    input wire tpeu_pkg::tpeu_emulation_instr_image_reg_kind_t trapKind,
    input wire logic [9:0] trapBhrbIdx,
    input wire logic compatWrEn,            // move to compatibility register
    input wire logic [0:63] compatWrData,
    input wire logic probState,             // decoding in problem state
    input wire tpeu_pkg::tpeu_isa_ver_t instrVer,
    input wire logic ciStValid,             // cache-inhibited store offered
    input wire logic [63:0] ciStAddr,
    input wire logic [3:0] ciStLen,         // bytes, 1 to 8
    output logic traceIntr,                 // one-cycle trace interrupt
    output logic pmuIntr,                   // one-cycle monitor interrupt
    output logic [0:63] saveRestoreAddrReg,
    output logic [0:63] saveRestoreStateReg,
    output logic [0:63] sampledInstrAddrReg,
    output logic [0:63] sampledDataAddrReg,
    output logic [0:63] dataFaultAddrReg,
    output logic [0:31] dataStorageCauseReg,
    output logic [0:31] emulationInstrImageReg,
    output logic [0:63] compatModeControl,
    output logic compatIllegal,             // decode must treat as illegal
    output logic gathStall,                 // gather window held open
    output logic gathFlush,                 // one-cycle gathered store out
    output logic [63:0] gathAddr,
    output logic [7:0] gathLen
);
    import tpeu_pkg::*;

    // trace decode
    logic teEvery;      // every-instruction mode
    logic teBranch;     // branch-only mode
    logic bkptHit;      // breakpoint address match
    logic traceHit;     // trace due for this completion
    logic isLoadRec;    // load flag, cleared for zero length
    logic isStoreRec;   // store flag, cleared for zero length
    logic sdarLoad;     // storage address is recorded

    assign teEvery = (traceEnableField == `TPEU_TE_EVERY);
    assign teBranch = (traceEnableField == `TPEU_TE_BRANCH);
    // field is sampled before the instruction, so a move that alters it still traces
    assign bkptHit = cmplValid & bkptEnable & (cmplEa == instrAddrBreakpointReg);
    assign traceHit = cmplValid & (teEvery | (teBranch & cmplIsBranch) | bkptHit);
    assign isLoadRec = cmplIsLoad & ~cmplZeroLenStr;
    assign isStoreRec = cmplIsStore & ~cmplZeroLenStr;
    assign sdarLoad = (cmplIsLoad | cmplIsStore) & ~cmplZeroLenStr;

    // saved state image for a trace
    logic [0:63] srr1Nxt;
    always_comb begin
        srr1Nxt = msrBits;
        srr1Nxt[`TPEU_S1_LOAD] = isLoadRec;
        srr1Nxt[`TPEU_S1_STORE] = isStoreRec;
        // unimplemented state bit always reads zero
        srr1Nxt[`TPEU_S1_UNIMP] = 1'b0;
        srr1Nxt[`TPEU_S1_BKPT] = bkptHit;
        srr1Nxt[`TPEU_S1_ZERO_LO:`TPEU_S1_ZERO_HI] = 4'h0;
    end

    // trace pulse and save/restore registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            traceIntr <= 1'b0;
            saveRestoreAddrReg <= 64'h0;
            saveRestoreStateReg <= 64'h0;
        end else begin
            traceIntr <= traceHit;
            if (traceHit) begin
                saveRestoreAddrReg <= cmplNextEa;
                saveRestoreStateReg <= srr1Nxt;
            end
        end
    end

    // sampled addresses have no reset: each is undefined until a trace first writes it
    always_ff @(posedge clk) begin
        if (traceHit) begin
            sampledInstrAddrReg <= cmplEa;
        end
        if (traceHit & sdarLoad) begin
            sampledDataAddrReg <= cmplDataEa;
        end
    end

    // monitor condition and drain sequencing
    tpeu_pmu_state_t pmState_r;
    tpeu_pmu_state_t pmState_nxt;
    logic pmCond;   // overflow seen while both enables set
    logic pmTake;   // deliver this cycle

    assign pmCond = externalEnableBit & monitorAlertEnable &
        ((|pmcOverflow) | nestOverflow);
    // trace owns the cycle; the monitor request stays pending behind it
    assign pmTake = (pmState_r == PM_DRAIN) & inflightEmpty & ~traceHit;

    // next state; a new overflow while taking keeps it pending
    always_comb begin
        pmState_nxt = pmState_r;
        case (pmState_r)
            PM_IDLE: begin
                if (pmCond) begin
                    pmState_nxt = PM_DRAIN;
                end
            end
            PM_DRAIN: begin
                if (pmTake & ~pmCond) begin
                    pmState_nxt = PM_IDLE;
                end
            end
            default: begin
                pmState_nxt = PM_IDLE;
            end
        endcase
    end

    // monitor state and pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pmState_r <= PM_IDLE;
            pmuIntr <= 1'b0;
        end else begin
            pmState_r <= pmState_nxt;
            pmuIntr <= pmTake;
        end
    end

    // fault address follows alignment; cause register only by software
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dataFaultAddrReg <= 64'h0;
            dataStorageCauseReg <= 32'h0;
        end else begin
            if (alignInt) begin
                dataFaultAddrReg <= alignEa;
            end
            // alignment deliberately has no path into the cause register
            if (causeWrEn) begin
                dataStorageCauseReg <= causeWrData;
            end
        end
    end

    // emulation image
    logic [0:31] heirImg;   // recoded trapped instruction
    tpeu_emulation_instr_image_reg_recode u_recode (
        .instr(trapInstr),
        .kind(trapKind),
        .bhrbIdx(trapBhrbIdx),
        .image(heirImg)
    );

    // image captured once per trap
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            emulationInstrImageReg <= 32'h0;
        end else if (trapValid) begin
            emulationInstrImageReg <= heirImg;
        end
    end

    // compatibility register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compatModeControl <= `TPEU_PCR_RST;
        end else if (compatWrEn) begin
            compatModeControl <= compatWrData;
        end
    end

    // decode reads the register live, so no cache flush is needed
    logic disV30;   // newest level off
    logic disV207;  // 2.07 additions off
    logic disV206;  // 2.06 additions off
    assign disV30 = compatModeControl[`TPEU_PCR_V30];
    assign disV207 = compatModeControl[`TPEU_PCR_V207];
    assign disV206 = compatModeControl[`TPEU_PCR_V206];
    assign compatIllegal = probState & (((instrVer == VER_30) & disV30) |
        ((instrVer == VER_207) & disV207) |
        ((instrVer == VER_206) & disV206));

    // store gathering
    logic gOpen_r;          // a gather is being built
    logic [63:0] gAddr_r;   // start address
    logic [7:0] gLen_r;     // bytes gathered
    logic [7:0] gWait_r;    // cycles since last merge
    logic [7:0] gSum;       // length after a merge
    logic gAdj;             // offered store extends the gather
    logic gExpire;          // stall window ran out
    logic gClose;           // emit current gather

    assign gSum = gLen_r + {4'h0, ciStLen};
    assign gAdj = gOpen_r & (ciStAddr == (gAddr_r + {56'h0, gLen_r})) &
        (gSum <= `TPEU_GATH_MAX);
    // holding the gather open trades latency for fewer bus writes
    assign gExpire = gOpen_r & (gWait_r == 8'(`TPEU_GATH_WAIT_CYC - 1));
    assign gClose = gOpen_r & ((ciStValid & ~gAdj) | (~ciStValid & gExpire));
    assign gathStall = gOpen_r;

    // gather buffer bookkeeping
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gOpen_r <= 1'b0;
            gAddr_r <= 64'h0;
            gLen_r <= 8'h00;
            gWait_r <= 8'h00;
        end else if (ciStValid & gAdj) begin
            gLen_r <= gSum;
            gWait_r <= 8'h00;
        end else if (ciStValid) begin
            gOpen_r <= 1'b1;
            gAddr_r <= ciStAddr;
            gLen_r <= {4'h0, ciStLen};
            gWait_r <= 8'h00;
        end else if (gExpire) begin
            gOpen_r <= 1'b0;
        end else if (gOpen_r) begin
            gWait_r <= gWait_r + 8'h01;
        end
    end

    // gathered store output
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gathFlush <= 1'b0;
            gathAddr <= 64'h0;
            gathLen <= 8'h00;
        end else begin
            gathFlush <= gClose;
            if (gClose) begin
                gathAddr <= gAddr_r;
                gathLen <= gLen_r;
            end
        end
    end

    // checks
    property p_trace_mode;
        @(posedge clk) disable iff (sys_rst)
        cmplValid && (teEvery || (teBranch && cmplIsBranch)) |=> traceIntr;
    endproperty
    a_trace_mode: assert property (p_trace_mode) else $error("trace missed");
    property p_no_trace;
        @(posedge clk) disable iff (sys_rst)
        !(cmplValid && (teEvery || (teBranch && cmplIsBranch) || bkptHit)) |=> !traceIntr;
    endproperty
    a_no_trace: assert property (p_no_trace) else $error("spurious trace");
    property p_bkpt;
        @(posedge clk) disable iff (sys_rst)
        bkptHit |=> traceIntr && saveRestoreStateReg[`TPEU_S1_BKPT];
    endproperty
    a_bkpt: assert property (p_bkpt) else $error("breakpoint trace wrong");
    property p_ldst;
        @(posedge clk) disable iff (sys_rst)
        traceHit |=> saveRestoreStateReg[`TPEU_S1_LOAD] == $past(isLoadRec) &&
            saveRestoreStateReg[`TPEU_S1_STORE] == $past(isStoreRec) &&
            saveRestoreStateReg[`TPEU_S1_ZERO_LO:`TPEU_S1_ZERO_HI] == 4'h0;
    endproperty
    a_ldst: assert property (p_ldst) else $error("saved state wrong");
    property p_sampled_instr_addr_reg;
        @(posedge clk) disable iff (sys_rst)
        traceHit && !bkptHit |=> sampledInstrAddrReg == $past(cmplEa);
    endproperty
    a_sampled_instr_addr_reg: assert property (p_sampled_instr_addr_reg) else $error("sampled address wrong");
    property p_pmu_gate;
        @(posedge clk) disable iff (sys_rst)
        pmuIntr |-> $past(inflightEmpty) && !traceIntr;
    endproperty
    a_pmu_gate: assert property (p_pmu_gate) else $error("monitor taken early");
    property p_pmu_kept;
        @(posedge clk) disable iff (sys_rst)
        pmCond && traceHit |=> pmState_r == PM_DRAIN;
    endproperty
    a_pmu_kept: assert property (p_pmu_kept) else $error("monitor event lost");
    property p_align;
        @(posedge clk) disable iff (sys_rst)
        alignInt && !causeWrEn |=> $stable(dataStorageCauseReg) &&
            dataFaultAddrReg == $past(alignEa);
    endproperty
    a_align: assert property (p_align) else $error("alignment update wrong");
    property p_compat;
        @(posedge clk) disable iff (sys_rst)
        compatWrEn |=> disV30 == $past(compatWrData[`TPEU_PCR_V30]) &&
            disV207 == $past(compatWrData[`TPEU_PCR_V207]) &&
            disV206 == $past(compatWrData[`TPEU_PCR_V206]);
    endproperty
    a_compat: assert property (p_compat) else $error("compat not applied");
endmodule

// File: bench/tpeu_exception_unit_test.sv
// self-checking bench of the exception unit, random stimulus with corner cases
`timescale 1ns/10ps
`include "tpeu_map.svh"
module tpeu_exception_unit_test;
    import tpeu_pkg::*;
    // design inputs, all driven by the bench
    logic clk, sys_rst, cmplValid, cmplIsBranch, cmplIsLoad, cmplIsStore, cmplZeroLenStr;
    logic externalEnableBit, monitorAlertEnable, nestOverflow, inflightEmpty, bkptEnable;
    logic alignInt, causeWrEn, trapValid, compatWrEn, probState, ciStValid;
    logic [0:63] cmplEa, cmplNextEa, cmplDataEa, msrBits, instrAddrBreakpointReg;
    logic [0:63] alignEa, compatWrData;
    logic [1:0] traceEnableField;
    logic [7:0] pmcOverflow;
    logic [0:31] causeWrData, trapInstr;
    tpeu_emulation_instr_image_reg_kind_t trapKind;
    logic [9:0] trapBhrbIdx;
    tpeu_isa_ver_t instrVer;
    logic [63:0] ciStAddr;
    logic [3:0] ciStLen;
    // design outputs
    logic traceIntr, pmuIntr, compatIllegal, gathStall, gathFlush;
    logic [0:63] saveRestoreAddrReg, saveRestoreStateReg, sampledInstrAddrReg;
    logic [0:63] sampledDataAddrReg, dataFaultAddrReg, compatModeControl;
    logic [0:31] dataStorageCauseReg, emulationInstrImageReg;
    logic [63:0] gathAddr;
    logic [7:0] gathLen;
    // bookkeeping
    int error_cnt = 0;
    int compares = 0;
    logic [31:0] rngState = 32'h0000_000C;
    logic [0:63] sdarExp; // last data address a plain trace recorded
    logic sdarKnown = 1'b0; // undefined until a trace has written it

    tpeu_exception_unit dut (.*);

    // free-running core clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // xorshift source, fixed start so runs repeat
    function automatic logic [31:0] xs();
        rngState = rngState ^ (rngState << 13);
        rngState = rngState ^ (rngState >> 17);
        rngState = rngState ^ (rngState << 5);
        return rngState;
    endfunction

    // expected saved state after a trace
    function automatic logic [0:63] expState(input logic [0:63] m, input logic ld, st, zl, bp);
        logic [0:63] r;
        r = m;
        r[`TPEU_S1_LOAD] = ld & ~zl;
        r[`TPEU_S1_STORE] = st & ~zl;
        r[`TPEU_S1_UNIMP] = 1'b0;
        r[`TPEU_S1_BKPT] = bp;
        r[`TPEU_S1_ZERO_LO:`TPEU_S1_ZERO_HI] = 4'h0;
        return r;
    endfunction

    // all drives happen right after a rising edge
    task automatic tk();
        @(posedge clk);
    endtask

    // the one compare, four-state exact
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one completing instruction, then the trace answer one cycle later
    task automatic trace(input logic [1:0] te, input logic br, ld, st, zl, bp);
        logic [0:63] ea, da, m;
        logic want;
        ea = {xs(), xs()};
        da = {xs(), xs()};
        m = {xs(), xs()};
        want = (te == `TPEU_TE_EVERY) | ((te == `TPEU_TE_BRANCH) & br) | bp;
        tk();
        cmplValid <= 1'b1;
        {cmplEa, cmplNextEa, cmplDataEa, msrBits} <= {ea, ea + 64'h4, da, m};
        {traceEnableField, cmplIsBranch, cmplIsLoad, cmplIsStore} <= {te, br, ld, st};
        {cmplZeroLenStr, bkptEnable} <= {zl, bp};
        instrAddrBreakpointReg <= bp ? ea : ~ea;
        tk();
        cmplValid <= 1'b0;
        // the traced instruction rewrote the field; its own trace must stand
        traceEnableField <= 2'h0;
        #1;
        chk(traceIntr, want, "trace pulse");
        if (want) begin
            chk(saveRestoreAddrReg, ea + 64'h4, "resume address");
            chk(saveRestoreStateReg, expState(m, ld, st, zl, bp), "saved state");
            // addresses undefined for breakpoint traces, left alone there
            if (!bp) begin
                chk(sampledInstrAddrReg, ea, "sampled instr");
                if ((ld | st) & ~zl) begin
                    sdarExp = da;
                    sdarKnown = 1'b1;
                end
                // zero-length strings must leave the last data address in place
                if (sdarKnown) begin
                    chk(sampledDataAddrReg, sdarExp, "sampled data");
                end
            end else if ((ld | st) & ~zl) begin
                sdarKnown = 1'b0;
            end
        end
    endtask

    // overflow event while older work drains, optionally a trace alongside
    task automatic pmu(input logic ee, pmae, input logic [8:0] ov, input logic tr, want);
        int nT, nP, both;
        {nT, nP, both} = {32'h0, 32'h0, 32'h0};
        tk();
        {externalEnableBit, monitorAlertEnable, inflightEmpty} <= {ee, pmae, 1'b0};
        {nestOverflow, pmcOverflow} <= ov;
        {cmplValid, traceEnableField, bkptEnable} <= {tr, `TPEU_TE_EVERY, 1'b0};
        for (int i = 0; i < 12; i++) begin
            tk();
            // a second completion lands on the cycle the drain ends
            {nestOverflow, pmcOverflow} <= 9'h000;
            cmplValid <= tr & (i == 4);
            inflightEmpty <= (i > 3);
            #1;
            nT += (traceIntr === 1'b1);
            nP += (pmuIntr === 1'b1);
            both += (traceIntr === 1'b1) && (pmuIntr === 1'b1);
            if (i < 4) begin
                chk(pmuIntr, 1'b0, "monitor before drain");
            end
        end
        chk(nP, want, "monitor takes");
        chk({nT, both}, {(tr ? 32'h2 : 32'h0), 32'h0}, "trace and monitor apart");
    endtask

    // trapped instruction into the emulation image
    task automatic trap(input tpeu_emulation_instr_image_reg_kind_t k, input logic [9:0] idx, output logic [0:31] ins);
        ins = xs();
        tk();
        trapValid <= 1'b1;
        trapKind <= k;
        {trapBhrbIdx, trapInstr} <= {idx, ins};
        tk();
        trapValid <= 1'b0;
        #1;
    endtask

    // main sequence
    initial begin
        logic [0:63] w, a;
        logic [0:31] ins, e, d;
        logic [9:0] idx;
        logic [31:0] r;
        logic hit;
        {cmplValid, cmplIsBranch, cmplIsLoad, cmplIsStore, cmplZeroLenStr} = 5'h00;
        {externalEnableBit, monitorAlertEnable, nestOverflow, bkptEnable, alignInt} = 5'h00;
        {causeWrEn, trapValid, compatWrEn, probState, ciStValid, pmcOverflow} = 13'h0000;
        {cmplEa, cmplNextEa, cmplDataEa, msrBits, instrAddrBreakpointReg} = 320'h0;
        {alignEa, compatWrData, causeWrData, trapInstr, ciStAddr} = 320'h0;
        {traceEnableField, trapBhrbIdx, ciStLen} = 16'h0000;
        trapKind = HK_NONE;
        instrVer = VER_BASE;
        {inflightEmpty, sys_rst} = 2'h3;
        repeat (12) tk();
        sys_rst <= 1'b0;
        tk();
        #1;
        chk({traceIntr, pmuIntr, gathFlush}, 3'h0, "pulses after reset");
        chk(compatModeControl, `TPEU_PCR_RST, "compat reset");
        // corners: zero-length store, breakpoint only, branch mode on non-branch
        trace(`TPEU_TE_EVERY, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        trace(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        trace(`TPEU_TE_BRANCH, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 48; i++) begin
            r = xs();
            trace((r[1:0] == 2'h3) ? 2'h2 : r[1:0], r[2], r[3], r[4] & ~r[3], r[5] & r[6],
                r[7] & r[8]);
        end
        // alignment after a software cause write
        d = xs();
        a = {xs(), xs()};
        tk();
        {causeWrEn, causeWrData} <= {1'b1, d};
        tk();
        {causeWrEn, alignInt, alignEa} <= {1'b0, 1'b1, a};
        tk();
        alignInt <= 1'b0;
        #1;
        chk(dataFaultAddrReg, a, "fault address");
        chk(dataStorageCauseReg, d, "cause kept");
        // monitor: each counter, the nest counter, missing enables
        for (int k = 0; k < 9; k++) begin
            pmu(1'b1, 1'b1, 9'(9'h001 << k), k == 3, 1'b1);
        end
        pmu(1'b0, 1'b1, 9'h0FF, 1'b0, 1'b0);
        pmu(1'b1, 1'b0, 9'h100, 1'b0, 1'b0);
        // history reads across the range edge, then clear, stop-fetch, branch
        for (int j = 0; j < 5; j++) begin
            idx = (j == 0) ? 10'h000 : (j == 1) ? 10'h01F : (j == 2) ? 10'h020 : 10'(xs());
            trap(HK_BHRB_RD, idx, ins);
            e[0:9] = (idx < `TPEU_BHRB_CNT) ? `TPEU_BHRB_BASE + idx : `TPEU_BHRB_OOR;
            chk(emulationInstrImageReg[11:20], e[0:9], "history read");
        end
        trap(HK_BHRB_CLR, 10'h000, ins);
        chk(emulationInstrImageReg[11:20], `TPEU_BHRB_OOR, "history clear");
        trap(HK_STOPF, 10'h000, ins);
        chk(emulationInstrImageReg[11:14], 4'hF, "stop fetch");
        chk(emulationInstrImageReg & 32'hFFE1_FFFF, ins & 32'hFFE1_FFFF, "stop rest");
        for (int j = 0; j < 6; j++) begin
            trap(HK_BCTAR, 10'h000, ins);
            // fixed pattern with the branch fields moved in; 9, 13, 31 free
            e = 32'h2018_0960;
            {e[1], e[5:8], e[10], e[15:18], e[21:22]} = {ins[31], ins[6:9], ins[11:15], ins[19:20]};
            chk(emulationInstrImageReg & 32'hFFBB_FFFE, e, "branch image");
        end
        // every compatibility setting against every level, both states
        for (int p = 0; p < 8; p++) begin
            w = 64'h0;
            w[`TPEU_PCR_V30:`TPEU_PCR_V206] = p[2:0];
            tk();
            {compatWrEn, compatWrData} <= {1'b1, w};
            tk();
            compatWrEn <= 1'b0;
            #1;
            chk(compatModeControl, w, "compat write");
            for (int v = 0; v < 8; v++) begin
                tk();
                probState <= v[2];
                instrVer <= tpeu_isa_ver_t'(v[1:0]);
                tk();
                #1;
                hit = (v[1:0] == 2'h3 && w[`TPEU_PCR_V30]) || (v[1:0] == 2'h2 && w[`TPEU_PCR_V207])
                    || (v[1:0] == 2'h1 && w[`TPEU_PCR_V206]);
                chk(compatIllegal, hit & v[2], "compat decode");
            end
        end
        // two adjacent inhibited stores gather into one after the stall window
        a = {xs(), xs() & 32'hFFFF_FFC0};
        tk();
        {ciStValid, ciStAddr, ciStLen} <= {1'b1, a, 4'h8};
        tk();
        ciStAddr <= a + 64'h8;
        tk();
        ciStValid <= 1'b0;
        #1;
        chk(gathStall, 1'b1, "gather open");
        hit = 1'b0;
        for (int i = 0; i < 20 && !hit; i++) begin
            tk();
            #1;
            if (gathFlush === 1'b1) begin
                hit = 1'b1;
                chk(gathAddr, a, "gathered address");
                chk(gathLen, 8'h10, "gathered length");
                chk(i + 1, `TPEU_GATH_WAIT_CYC, "gather wait");
                chk(gathStall, 1'b0, "gather closed");
            end
        end
        if (!hit) begin
            error_cnt++;
            $display("Error at %0t: gathered store never left", $time);
        end
        // a store that does not extend the gather pushes it out at once
        tk();
        {ciStValid, ciStAddr, ciStLen} <= {1'b1, a, 4'h4};
        tk();
        ciStAddr <= a + 64'h40;
        tk();
        ciStValid <= 1'b0;
        #1;
        chk({gathFlush, gathLen}, {1'b1, 8'h04}, "flush on gap");
        chk(gathAddr, a, "flushed address");
        stop_test();
    end
endmodule
